// *** logic/tcd_pkg.sv ***
/*
  package for the tape controller host interface: register layouts,
  command codes, status bit positions and device-flag functions.
  assumes a host i/o bus that presents one instruction per cycle.
*/
// Notes on behaviour
// - start sets busy except for rewind, clears done, runs command
// - start clears errors only if illegal clear
// - clear zeroes flags, unit zero, read command
// - load command takes accumulator bits 9-15
// - command bit 9 picks NRZI parity
// - command bits 10-12 decode the operation
// - command bits 13-15 select the transport
// - read status returns word, then flag function
// - error bit ORs bits 1,3,5,6,7,8,10,14
// - data late on channel timeout; rewinding shown
// - illegal on not ready, leader, protect
// - high density bit, always 1 on PE
// - parity error on byte or check mismatch
// - end of tape set, cleared by reverse/rewind
// - file mark flag; beginning of tape shown
// - nine-track bit, always 1 on PE
// - bad tape flag; bits 11-12 maintenance
// - write lock, odd count, unit ready shown
// - load address takes all 16 accumulator bits
// - address bit 0 selects maintenance mode except on PE
// - 15-bit address counter increments per word
// - one moving transport, many may rewind
// - word counter holds two's complement count
// - finish clears busy, sets done, interrupts
package tcd_pkg;
  // device-flag function codes
  localparam logic [1:0] FN_NONE  = 2'h0;
  localparam logic [1:0] FN_START = 2'h1;
  localparam logic [1:0] FN_CLEAR = 2'h2;
  localparam logic [1:0] FN_PULSE = 2'h3;
  // command codes
  localparam logic [2:0] CMD_READ  = 3'h0;
  localparam logic [2:0] CMD_REWND = 3'h1;
  localparam logic [2:0] CMD_RSVD  = 3'h2;
  localparam logic [2:0] CMD_SPFWD = 3'h3;
  localparam logic [2:0] CMD_SPREV = 3'h4;
  localparam logic [2:0] CMD_WRITE = 3'h5;
  localparam logic [2:0] CMD_WFM   = 3'h6;
  localparam logic [2:0] CMD_ERASE = 3'h7;
  // status positions, bit 0 is the msb in host numbering
  localparam int ST_ERR = 15;
  localparam int ST_LATE = 14;
  localparam int ST_REW = 13;
  localparam int ST_ILL = 12;
  localparam int ST_HID = 11;
  localparam int ST_PAR = 10;
  localparam int ST_EOT = 9;
  localparam int ST_EOF = 8;
  localparam int ST_BOT = 7;
  localparam int ST_NINE = 6;
  localparam int ST_BAD = 5;
  localparam int ST_SCLK = 4;
  localparam int ST_FCH = 3;
  localparam int ST_WLK = 2;
  localparam int ST_ODD = 1;
  localparam int ST_RDY = 0;
  // word counter width, large form
  localparam int WC_W = 16;
  localparam logic [2:0]  CMDU_RST_UNIT = 3'h0;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // command/unit register, host bits 9..15
  typedef struct packed {
    logic       even_par;
    logic [2:0] cmd;
    logic [2:0] unit;
  } tcd_cmdu_t;
  // per-transport sense lines
  typedef struct packed {
    logic ready;
    logic bot;
    logic eot;
    logic wlock;
    logic nine;
    logic hi_den;
  } tcd_xport_t;
  // events reported by the tape datapath at the end of a record
  typedef struct packed {
    logic done;
    logic late;
    logic par_err;
    logic fmark;
    logic bad;
    logic odd;
  } tcd_evt_t;
  typedef enum logic [1:0] {S_IDLE, S_RUN} tcd_state_t;
endpackage

// *** logic/tcd_ctrl.sv ***
/*
  tape controller host interface: command/unit, status, address and
  word counter, busy/done flags and the run/rewind launch logic.
  assumes the host bus and the tape datapath are on sys_clk and that
  bus strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
module tcd_ctrl #(
  parameter bit PE_MODE = 1'b0
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // host instructions
  input  wire logic                  load_cmd_stb,
  input  wire logic                  read_stat_stb,
  input  wire logic                  load_addr_stb,
  input  wire logic                  read_addr_stb,
  input  wire logic                  load_cnt_stb,
  input  wire logic                  pulse_stb,
  input  wire logic [1:0]            func,
  input  wire logic [15:0]           acc_in,
  output logic      [15:0]           acc_out,
  output logic                       acc_valid,
  output logic                       busy,
  output logic                       done,
  output logic                       irq_req,
  // data channel word events
  input  wire logic                  word_xfer,
  input  wire logic                  chan_late,
  output logic      [14:0]           mem_addr,
  output logic                       maint_mode,
  output logic      [15:0]           word_cnt,
  output logic                       wc_ovf,
  // transports
  input  tcd_pkg::tcd_xport_t [7:0]  xport,
  input  wire logic [7:0]            rew_busy,
  input  tcd_pkg::tcd_evt_t          evt,
  output logic      [2:0]            sel_unit,
  output logic      [2:0]            run_cmd,
  output logic                       even_parity,
  output logic                       op_go,
  output logic      [7:0]            rew_go
);
  tcd_pkg::tcd_cmdu_t cmdu_q, cmdu_d;
  tcd_pkg::tcd_state_t st_q;
  logic [15:0] addr_q;
  logic [15:0] wc_q;
  logic busy_q, done_q;
  logic late_q, ill_q, par_q, eot_q, eof_q, bad_q, odd_q;
  logic [15:0] acc_q;
  logic acc_v_q, go_q, ovf_q;
  logic [7:0] rew_q;

  // host instruction carries a device-flag function
  wire any_stb = load_cmd_stb | read_stat_stb | load_addr_stb |
                 read_addr_stb | load_cnt_stb | pulse_stb;
  wire f_start = any_stb && func == tcd_pkg::FN_START;
  wire f_clear = any_stb && func == tcd_pkg::FN_CLEAR;

  // load-command field split (host bit 9 is bit 6 here)
  assign cmdu_d = load_cmd_stb ? tcd_pkg::tcd_cmdu_t'(acc_in[6:0])
                               : cmdu_q;
  // PE controller only has units 0-3
  wire [2:0] unit_eff = PE_MODE ? {1'b0, cmdu_d.unit[1:0]}
                                : cmdu_d.unit;
  tcd_pkg::tcd_xport_t sx;
  assign sx = xport[unit_eff];
  wire [2:0] c = cmdu_d.cmd;
  wire wr_cmd = c == tcd_pkg::CMD_WRITE || c == tcd_pkg::CMD_WFM ||
                c == tcd_pkg::CMD_ERASE;
  wire illegal_now = !sx.ready ||
                     (c == tcd_pkg::CMD_SPREV && sx.bot) ||
                     (wr_cmd && sx.wlock);
  // a moving operation is refused while another runs
  wire launch = f_start && !illegal_now && st_q == tcd_pkg::S_IDLE;
  wire is_rew = c == tcd_pkg::CMD_REWND;

  // status word, host bit 0 at [15]
  logic [15:0] stat;
  always_comb begin
    stat = tcd_pkg::ZERO16;
    stat[tcd_pkg::ST_LATE] = late_q;
    stat[tcd_pkg::ST_REW] = rew_busy[cmdu_q.unit] | rew_q[cmdu_q.unit];
    stat[tcd_pkg::ST_ILL] = ill_q;
    stat[tcd_pkg::ST_HID] = PE_MODE | xport[cmdu_q.unit].hi_den;
    stat[tcd_pkg::ST_PAR] = par_q;
    stat[tcd_pkg::ST_EOT] = eot_q;
    stat[tcd_pkg::ST_EOF] = eof_q;
    stat[tcd_pkg::ST_BOT] = xport[cmdu_q.unit].bot;
    stat[tcd_pkg::ST_NINE] = PE_MODE | xport[cmdu_q.unit].nine;
    stat[tcd_pkg::ST_BAD] = bad_q;
    stat[tcd_pkg::ST_WLK] = xport[cmdu_q.unit].wlock;
    stat[tcd_pkg::ST_ODD] = odd_q;
    stat[tcd_pkg::ST_RDY] = xport[cmdu_q.unit].ready;
    stat[tcd_pkg::ST_ERR] = late_q | ill_q | par_q | eot_q | eof_q |
                            stat[tcd_pkg::ST_BOT] | bad_q | odd_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdu_q <= '0;
      acc_q <= tcd_pkg::ZERO16;
      acc_v_q <= 1'b0;
    end else begin
      // clear selects unit 0 and read
      if (f_clear)
        cmdu_q <= '{even_par: cmdu_d.even_par, cmd: tcd_pkg::CMD_READ,
                    unit: tcd_pkg::CMDU_RST_UNIT};
      else
        cmdu_q <= cmdu_d;
      acc_v_q <= read_stat_stb | read_addr_stb;
      // status returned before the flag function applies
      if (read_stat_stb)
        acc_q <= stat;
      else if (read_addr_stb)
        acc_q <= addr_q;
    end
  end

  // address counter, bit 15 holds maintenance
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      addr_q <= tcd_pkg::ZERO16;
    else if (load_addr_stb)
      addr_q <= acc_in;
    else if (word_xfer && st_q == tcd_pkg::S_RUN)
      addr_q <= {addr_q[15], addr_q[14:0] + 15'h0001};
  end

  // word counter counts up from two's complement
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wc_q <= tcd_pkg::ZERO16;
      ovf_q <= 1'b0;
    end else if (load_cnt_stb) begin
      wc_q <= PE_MODE ? acc_in : {4'h0, acc_in[11:0]};
      ovf_q <= 1'b0;
    end else if (word_xfer && st_q == tcd_pkg::S_RUN) begin
      wc_q <= PE_MODE ? wc_q + 16'h0001
                      : {4'h0, wc_q[11:0] + 12'h001};
      ovf_q <= PE_MODE ? wc_q == 16'hFFFF : wc_q[11:0] == 12'hFFF;
    end
  end

  wire fin = st_q == tcd_pkg::S_RUN && evt.done;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= tcd_pkg::S_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      go_q <= 1'b0;
      rew_q <= 8'h00;
    end else begin
      go_q <= 1'b0;
      rew_q <= 8'h00;
      case (st_q)
        tcd_pkg::S_IDLE: begin
          if (launch && !is_rew) begin
            st_q <= tcd_pkg::S_RUN;
            go_q <= 1'b1;
          end
        end
        tcd_pkg::S_RUN: begin
          if (fin || f_clear)
            st_q <= tcd_pkg::S_IDLE;
        end
        default: st_q <= tcd_pkg::S_IDLE;
      endcase
      // any unit may be sent to rewind
      if (launch && is_rew)
        rew_q[unit_eff] <= 1'b1;
      if (f_clear) begin
        busy_q <= 1'b0;
        done_q <= 1'b0;
      end else if (f_start) begin
        busy_q <= !is_rew;
        done_q <= 1'b0;
      end else if (fin) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // error flags; hardware set wins over start clear
  wire err_clr = f_clear | (f_start && !ill_q);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {late_q, ill_q, par_q, eot_q, eof_q, bad_q, odd_q} <= 7'h00;
    end else begin
      // start clears errors only when illegal is 0
      if (err_clr)
        {late_q, par_q, eof_q, bad_q, odd_q} <= 5'h00;
      if (f_clear)
        ill_q <= 1'b0;
      else if (f_start)
        ill_q <= illegal_now;
      // end of tape, cleared by reverse or rewind
      if (st_q == tcd_pkg::S_RUN && xport[cmdu_q.unit].eot)
        eot_q <= 1'b1;
      else if (f_clear || (launch &&
               (c == tcd_pkg::CMD_SPREV || is_rew)))
        eot_q <= 1'b0;
      if (st_q == tcd_pkg::S_RUN) begin
        if (chan_late)
          late_q <= 1'b1;
        if (evt.par_err)
          par_q <= 1'b1;
        if (evt.fmark)
          eof_q <= 1'b1;
        if (evt.bad)
          bad_q <= 1'b1;
        if (evt.odd)
          odd_q <= 1'b1;
      end
    end
  end

  assign acc_out = acc_q;
  assign acc_valid = acc_v_q;
  assign busy = busy_q;
  assign done = done_q;
  assign irq_req = done_q;
  assign mem_addr = addr_q[14:0];
  assign maint_mode = addr_q[15] & !PE_MODE;
  assign word_cnt = wc_q;
  assign wc_ovf = ovf_q;
  assign sel_unit = cmdu_q.unit;
  assign run_cmd = cmdu_q.cmd;
  assign even_parity = cmdu_q.even_par & !PE_MODE;
  assign op_go = go_q;
  assign rew_go = rew_q;

  // start other than rewind makes busy and clears done
  property p_start_busy;
    @(posedge sys_clk) disable iff (!rst_n)
      (f_start && !f_clear && !is_rew) |=> busy && !done;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not set busy");

  property p_clear_flags;
    @(posedge sys_clk) disable iff (!rst_n)
      f_clear |=> !busy && !done && sel_unit == 3'h0 && !ill_q;
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("clear left flags set");

  sequence s_fin;
    st_q == tcd_pkg::S_RUN && evt.done && !any_stb;
  endsequence
  property p_finish;
    @(posedge sys_clk) disable iff (!rst_n)
      s_fin |=> done && !busy ##0 irq_req;
  endproperty
  a_finish: assert property (p_finish)
    else $error("finish did not raise done");

  property p_err_sum;
    @(posedge sys_clk) disable iff (!rst_n)
      ill_q |-> stat[tcd_pkg::ST_ERR];
  endproperty
  a_err_sum: assert property (p_err_sum)
    else $error("error summary missing");

  property p_addr_inc;
    @(posedge sys_clk) disable iff (!rst_n)
      (word_xfer && st_q == tcd_pkg::S_RUN && !load_addr_stb) |=>
        mem_addr == $past(mem_addr) + 15'h0001;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address did not step");

  property p_illegal;
    @(posedge sys_clk) disable iff (!rst_n)
      (f_start && !f_clear && illegal_now) |=> ill_q && !op_go;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal start not flagged");

  property p_one_run;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q == tcd_pkg::S_RUN |=> !op_go;
  endproperty
  a_one_run: assert property (p_one_run)
    else $error("second operation launched");

  property p_load_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
      (load_cmd_stb && !f_clear) |=>
        run_cmd == $past(acc_in[5:3]) && sel_unit == $past(acc_in[2:0]);
  endproperty
  a_load_cmd: assert property (p_load_cmd)
    else $error("command not loaded");
endmodule

// *** dv/tcd_xport_model.sv ***
/*
  behavioural tape transports and datapath on the far side of tcd_ctrl.
  assumes units 0-2 are fitted with fixed sense lines, the others empty.
*/
`timescale 1ns/1ps
module tcd_xport_model (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // launches from the controller, record flags from the bench
  input  wire logic                 op_go,
  input  wire logic [7:0]           rew_go,
  input  tcd_pkg::tcd_evt_t         flags,
  // sense lines and end-of-record events
  output tcd_pkg::tcd_xport_t [7:0] xport,
  output logic      [7:0]           rew_busy,
  output tcd_pkg::tcd_evt_t         evt
);
  logic [3:0] run_q;
  logic [4:0] rew_q [8];

  // unit0 ready at bot, 9-track, 800bpi; unit1 ready; unit2 ready, locked
  assign xport = {30'h00000000, 6'h24, 6'h20, 6'h33};

  // a moving operation ends twelve cycles after launch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 4'h0;
      evt   <= '0;
    end else begin
      evt <= '0;
      if (op_go) begin
        run_q <= 4'hC;
      end else if (run_q != 4'h0) begin
        run_q <= run_q - 4'h1;
      end
      if (run_q == 4'h1) begin
        evt      <= flags;
        evt.done <= 1'b1;
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_rew
    assign rew_busy[i] = (rew_q[i] != 5'h00);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        rew_q[i] <= 5'h00;
      end else if (rew_go[i]) begin
        rew_q[i] <= 5'h1E;
      end else if (rew_q[i] != 5'h00) begin
        rew_q[i] <= rew_q[i] - 5'h01;
      end
    end
  end
endmodule

// *** dv/tb.sv ***
/*
  self-checking bench for tcd_ctrl: host instructions through strobes.
  assumes the transport model in tcd_xport_model answers the far side.
*/
`timescale 1ns/1ps
module tb;
  localparam int LC = 0;
  localparam int RS = 1;
  localparam int LA = 2;
  localparam int RA = 3;
  localparam int LW = 4;
  localparam int PL = 5;

  logic                       sys_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [5:0]                 stb = 6'h00;
  logic [1:0]                 func = 2'h0;
  logic [15:0]                acc_in = 16'h0000;
  logic [15:0]                acc_out;
  logic                       acc_valid;
  logic                       busy;
  logic                       done;
  logic                       irq_req;
  logic                       word_xfer = 1'b0;
  logic                       chan_late = 1'b0;
  logic [14:0]                mem_addr;
  logic                       maint_mode;
  logic [15:0]                word_cnt;
  logic                       wc_ovf;
  tcd_pkg::tcd_xport_t [7:0]  xport;
  logic [7:0]                 rew_busy;
  tcd_pkg::tcd_evt_t          evt;
  tcd_pkg::tcd_evt_t          flags = '0;
  logic [2:0]                 sel_unit;
  logic [2:0]                 run_cmd;
  logic                       even_parity;
  logic                       op_go;
  logic [7:0]                 rew_go;
  int                         err_total = 0;
  int                         n_compared = 0;
  int                         cyc = 0;

  always #2 sys_clk = ~sys_clk;

  tcd_ctrl #(.PE_MODE(1'b0)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .load_cmd_stb(stb[LC]),
    .read_stat_stb(stb[RS]), .load_addr_stb(stb[LA]),
    .read_addr_stb(stb[RA]), .load_cnt_stb(stb[LW]), .pulse_stb(stb[PL]),
    .func(func), .acc_in(acc_in), .acc_out(acc_out),
    .acc_valid(acc_valid), .busy(busy), .done(done), .irq_req(irq_req),
    .word_xfer(word_xfer), .chan_late(chan_late), .mem_addr(mem_addr),
    .maint_mode(maint_mode), .word_cnt(word_cnt), .wc_ovf(wc_ovf),
    .xport(xport), .rew_busy(rew_busy), .evt(evt), .sel_unit(sel_unit),
    .run_cmd(run_cmd), .even_parity(even_parity), .op_go(op_go),
    .rew_go(rew_go));

  tcd_xport_model far (
    .sys_clk(sys_clk), .rst_n(rst_n), .op_go(op_go), .rew_go(rew_go),
    .flags(flags), .xport(xport), .rew_busy(rew_busy), .evt(evt));

  task automatic close_out;
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] sb(input int p);
    return 16'h0001 << p;
  endfunction

  // one instruction; returns just after the edge that answers it
  task automatic io(input int k, input logic [1:0] f,
                    input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    stb[k] = 1'b1;
    func   = f;
    acc_in = d;
    @(posedge sys_clk);
    #1;
    stb = 6'h00;
  endtask

  // status compare with the maintenance bits masked off
  task automatic stat(input logic [15:0] exp);
    io(RS, tcd_pkg::FN_NONE, 16'h0000);
    chk("valid", acc_valid, 1'b1);
    chk("status", acc_out & ~(sb(tcd_pkg::ST_SCLK) | sb(tcd_pkg::ST_FCH)),
        exp);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge sys_clk);
    #1;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk("busy", busy, 1'b0);
    for (int c = 0; c < 8; c++) begin
      io(LC, tcd_pkg::FN_NONE, {9'h1FF, 1'b1, c[2:0], 3'h1});
      chk("run_cmd", run_cmd, c[2:0]);
    end
    chk("sel_unit", sel_unit, 3'h1);
    chk("parity", even_parity, 1'b1);
    io(LA, tcd_pkg::FN_NONE, 16'h8010);
    chk("address", mem_addr, 15'h0010);
    chk("maint", maint_mode, 1'b1);
    io(LW, tcd_pkg::FN_NONE, 16'hFFFE);
    chk("count", word_cnt[11:0], 12'hFFE);
    flags.par_err = 1'b1;
    io(LC, tcd_pkg::FN_START, {9'h000, 1'b0, tcd_pkg::CMD_WRITE, 3'h1});
    chk("go", {busy, done, op_go}, 3'b101);
    word_xfer = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    word_xfer = 1'b0;
    chan_late = 1'b1;
    @(posedge sys_clk);
    #1;
    chan_late = 1'b0;
    wait_done();
    chk("finish", {busy, done, irq_req}, 3'b011);
    chk("address", mem_addr, 15'h0012);
    chk("count", word_cnt, 16'h0000);
    chk("overflow", wc_ovf, 1'b1);
    io(RA, tcd_pkg::FN_NONE, 16'h0000);
    chk("read addr", acc_out[14:0], 15'h0012);
    stat(sb(tcd_pkg::ST_ERR) | sb(tcd_pkg::ST_LATE) | sb(tcd_pkg::ST_PAR)
         | sb(tcd_pkg::ST_RDY));
    flags = '0;
    io(RS, tcd_pkg::FN_START, 16'h0000);
    chk("busy", busy, 1'b1);
    wait_done();
    stat(sb(tcd_pkg::ST_RDY));
    io(LC, tcd_pkg::FN_START, {9'h000, 1'b0, tcd_pkg::CMD_ERASE, 3'h2});
    chk("refused go", op_go, 1'b0);
    stat(sb(tcd_pkg::ST_ERR) | sb(tcd_pkg::ST_ILL) | sb(tcd_pkg::ST_WLK)
         | sb(tcd_pkg::ST_RDY));
    io(PL, tcd_pkg::FN_CLEAR, 16'h0000);
    chk("cleared", {busy, done, sel_unit, run_cmd}, 8'h00);
    stat(sb(tcd_pkg::ST_ERR) | sb(tcd_pkg::ST_BOT) | sb(tcd_pkg::ST_NINE)
         | sb(tcd_pkg::ST_HID) | sb(tcd_pkg::ST_RDY));
    io(LC, tcd_pkg::FN_START, {9'h000, 1'b0, tcd_pkg::CMD_REWND, 3'h0});
    chk("rewind", {busy, done, op_go, rew_go}, 11'h001);
    io(RS, tcd_pkg::FN_NONE, 16'h0000);
    chk("rewinding", acc_out[tcd_pkg::ST_REW], 1'b1);
    io(LC, tcd_pkg::FN_START, {9'h000, 1'b0, tcd_pkg::CMD_SPREV, 3'h0});
    chk("refused go", op_go, 1'b0);
    io(RS, tcd_pkg::FN_NONE, 16'h0000);
    chk("illegal", acc_out[tcd_pkg::ST_ILL], 1'b1);
    close_out();
  end
endmodule
